/* pkg/hpm_pkg.sv */
// Shared constants and types for the host port pin mode select
// ====================================================================
// How it works
// - Clock select low feeds PLL, high bypasses
// - Parallel mode: data pins are host bus
// - Serial with memory: data pins multiplex memory
// - Serial without memory: data pins are GPIO
// - Two address pins pick one of four registers
// - Serial mode: low address pin is clock
// - SPI mode: high address pin is data in
// - Read pin is direction or output enable
// - Serial mode: read pin is memory OE or GPIO
// - Write pin is write strobe or data strobe
// - Serial mode: write pin is memory WE or GPIO
// - Chip select low addresses device, high ignored
// - Reset low makes every two-way pin input
// - Mode latched from pins at reset release
// - Serial mode with autoboot low starts boot
// - I2C data open drain, SPI data output
// - Port type pin picks parallel bus style
// - Parallel mode: port type pin becomes GPIO after latch
// - Autoboot pin held low through release boots, serial modes only
// - Serial: memory select is ROM select, else GPIO
package hpm_pkg;

  // ==================================================================
  // Modes
  typedef enum logic [1:0] {HPM_PAR, HPM_SPI, HPM_I2C} hpm_mode_t;

  // ==================================================================
  // Pin bit positions in the synchronised pin vector
  localparam int DATA_WIDTH = 8;
  localparam int GPIO_COUNT = 12;
  localparam int PIN_EXT_SEL = 8;
  localparam int PIN_SDIO = 9;
  localparam int PIN_WR = 10;
  localparam int PIN_RD = 11;
  localparam int PIN_ADDR0 = 12;
  localparam int PIN_ADDR1 = 13;
  localparam int PIN_CS = 14;
  localparam int PIN_CLK_SEL = 15;
  localparam int PIN_AUTO_BOOT_REQUEST_N = 16;
  localparam int SYNC_WIDTH = 17;

  // ==================================================================
  // Host controller registers (APB, byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_RELEASE_BIT = 0;
  localparam int CTRL_PAR_BIT = 1;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_CORE_CLOCK_SOURCE_SELECT_BIT = 3;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WRITE_BIT = 10;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_STRAP_BIT = 1;
  localparam int STATUS_RDATA_LSB = 8;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ==================================================================
  // Host bus phase lengths in core_clk cycles
  localparam logic [3:0] SETUP_CYCLES = 4'h4;
  localparam logic [3:0] STROBE_CYCLES = 4'h8;
  localparam logic [3:0] HOLD_CYCLES = 4'h4;

endpackage

/* pkg/hpm_pins_if.sv */
// Shared host-side pins between device end and host end
`timescale 1ns/1ns
interface hpm_pins_if;
  // Two-way pins: each end drives out and an active-low enable; ext select and autoboot have one end only
  logic [7:0] dataDevOut, dataDevOen, dataHostOut, dataHostOen, dataLine;
  logic rdDevOut, rdDevOen, rdHostOut, rdHostOen, rdLine;
  logic wrDevOut, wrDevOen, wrHostOut, wrHostOen, wrLine;
  logic sdioDevOut, sdioDevOen, sdioHostOut, sdioHostOen, sdioLine;
  logic extSelDevOut, extSelDevOen, extSelLine;
  logic abootHostOut, abootHostOen, abootLine;
  // Input-only pins driven by the host
  logic addr0, addr1, csN, core_clock_source_select;

  // ==================================================================
  // Wire resolution, undriven lines float high on pull-ups
  assign dataLine = (~dataDevOen & dataDevOut) | (dataDevOen & ~dataHostOen & dataHostOut)
                  | (dataDevOen & dataHostOen);
  assign rdLine = !rdDevOen ? rdDevOut : (!rdHostOen ? rdHostOut : 1'b1);
  assign wrLine = !wrDevOen ? wrDevOut : (!wrHostOen ? wrHostOut : 1'b1);
  assign sdioLine = !sdioDevOen ? sdioDevOut : (!sdioHostOen ? sdioHostOut : 1'b1);
  assign extSelLine = !extSelDevOen ? extSelDevOut : 1'b1;
  assign abootLine = !abootHostOen ? abootHostOut : 1'b1;

  modport device (
    input dataLine, rdLine, wrLine, sdioLine, extSelLine, abootLine,
    input addr0, addr1, csN, core_clock_source_select,
    output dataDevOut, dataDevOen, rdDevOut, rdDevOen, wrDevOut, wrDevOen,
    output sdioDevOut, sdioDevOen, extSelDevOut, extSelDevOen
  );
  modport host (
    input dataLine, rdLine, wrLine, sdioLine, extSelLine, abootLine,
    output dataHostOut, dataHostOen, rdHostOut, rdHostOen, wrHostOut, wrHostOen,
    output sdioHostOut, sdioHostOen, abootHostOut, abootHostOen,
    output addr0, addr1, csN, core_clock_source_select
  );
endinterface

/* hw/hpm_device_end.sv */
// Device end: strap latch and role mux of the shared host pins
`timescale 1ns/1ns
module hpm_device_end #(
  parameter hpm_pkg::hpm_mode_t MODE_RD0_WR0 = hpm_pkg::HPM_PAR,
  parameter hpm_pkg::hpm_mode_t MODE_RD0_WR1 = hpm_pkg::HPM_I2C,
  parameter hpm_pkg::hpm_mode_t MODE_RD1_WR0 = hpm_pkg::HPM_SPI,
  parameter hpm_pkg::hpm_mode_t MODE_RD1_WR1 = hpm_pkg::HPM_PAR,
  parameter logic PSEL_DIR_LEVEL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rstn,
  hpm_pins_if.device pins,
  // Processor controls
  input wire logic extMemEnable,
  input wire logic [hpm_pkg::GPIO_COUNT-1:0] gpioOut,
  input wire logic [hpm_pkg::GPIO_COUNT-1:0] gpioDir,
  input wire logic [hpm_pkg::DATA_WIDTH-1:0] memAddrData,
  input wire logic memDrive,
  input wire logic memOeN,
  input wire logic memWeN,
  input wire logic romSelN,
  input wire logic [hpm_pkg::DATA_WIDTH-1:0] parReadData,
  input wire logic spiOut,
  input wire logic i2cDriveLow,
  // Status towards the processor
  output logic modeValid,
  output hpm_pkg::hpm_mode_t hostMode,
  output logic dirStyle,
  output logic autoBootStart,
  output logic usePll,
  output logic [1:0] parAddr,
  output logic [3:0] parRegSel,
  output logic [hpm_pkg::DATA_WIDTH-1:0] parWriteData,
  output logic parWriteStrobe,
  output logic parReadActive,
  output logic serialClk,
  output logic spiDataIn,
  output logic spiCsN,
  output logic i2cDataIn,
  output logic [hpm_pkg::GPIO_COUNT-1:0] gpioIn
);

  localparam int DW = hpm_pkg::DATA_WIDTH;
  localparam int SW = hpm_pkg::SYNC_WIDTH;

  logic [SW-1:0] pinRaw;
  logic [SW-1:0] syncA_q;
  logic [SW-1:0] syncB_q;
  logic latched_q;
  hpm_pkg::hpm_mode_t mode_q;
  hpm_pkg::hpm_mode_t strapMode;
  logic dirStyle_q;
  logic autoBoot_q;
  logic usePll_q;
  logic isPar, isSpi, isI2c, isSer;
  logic csLow, rdLvl, wrLvl;
  logic readWin, writeAct, writeAct_q;
  logic [1:0] parAddr_q;
  logic [3:0] parRegSel_q;
  logic [DW-1:0] parWriteData_q;
  logic parWriteStrobe_q, parReadActive_q;
  logic serialClk_q, spiDataIn_q, spiCsN_q, i2cDataIn_q;
  logic [hpm_pkg::GPIO_COUNT-1:0] gpioIn_q;
  logic [DW-1:0] dataOut_d, dataOen_d, dataOut_q, dataOen_q;
  logic rdOut_d, rdOen_d, rdOut_q, rdOen_q;
  logic wrOut_d, wrOen_d, wrOut_q, wrOen_q;
  logic sdioOut_d, sdioOen_d, sdioOut_q, sdioOen_q;
  logic extOut_d, extOen_d, extOut_q, extOen_q;

  // ==================================================================
  // Pin synchroniser
  assign pinRaw = {pins.abootLine, pins.core_clock_source_select, pins.csN, pins.addr1, pins.addr0,
                   pins.rdLine, pins.wrLine, pins.sdioLine, pins.extSelLine,
                   pins.dataLine};

  // Left unreset so the strap levels are already through it at release
  always_ff @(posedge core_clk) begin
    syncA_q <= pinRaw;
    syncB_q <= syncA_q;
  end

  assign csLow = ~syncB_q[hpm_pkg::PIN_CS];
  assign rdLvl = syncB_q[hpm_pkg::PIN_RD];
  assign wrLvl = syncB_q[hpm_pkg::PIN_WR];

  // ==================================================================
  // Strap decode and latch
  function automatic hpm_pkg::hpm_mode_t pickMode(input logic rdBit, input logic wrBit);
    case ({rdBit, wrBit})
      2'b00: pickMode = MODE_RD0_WR0;
      2'b01: pickMode = MODE_RD0_WR1;
      2'b10: pickMode = MODE_RD1_WR0;
      default: pickMode = MODE_RD1_WR1;
    endcase
  endfunction

  assign strapMode = pickMode(rdLvl, wrLvl);

  // Caught once, on the first edge after release
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      latched_q <= 1'b0;
      mode_q <= hpm_pkg::HPM_PAR;
      dirStyle_q <= 1'b0;
    end else if (!latched_q) begin
      latched_q <= 1'b1;
      mode_q <= strapMode;
      dirStyle_q <= (syncB_q[hpm_pkg::PIN_SDIO] == PSEL_DIR_LEVEL);
    end
  end

  // One-cycle boot request in the latch cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      autoBoot_q <= 1'b0;
    end else begin
      autoBoot_q <= !latched_q && (strapMode != hpm_pkg::HPM_PAR)
                    && !syncB_q[hpm_pkg::PIN_AUTO_BOOT_REQUEST_N];
    end
  end

  assign isPar = latched_q && (mode_q == hpm_pkg::HPM_PAR);
  assign isSpi = latched_q && (mode_q == hpm_pkg::HPM_SPI);
  assign isI2c = latched_q && (mode_q == hpm_pkg::HPM_I2C);
  assign isSer = isSpi || isI2c;

  // ==================================================================
  // Clock source select
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      usePll_q <= 1'b1;
    end else begin
      usePll_q <= ~syncB_q[hpm_pkg::PIN_CLK_SEL];
    end
  end

  // ==================================================================
  // Parallel host port decode
  // Direction style: read pin is R/W, write pin is data strobe
  assign readWin = isPar && csLow && (dirStyle_q ? (rdLvl && !wrLvl) : !rdLvl);
  assign writeAct = isPar && csLow && (dirStyle_q ? (!rdLvl && !wrLvl) : !wrLvl);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      writeAct_q <= 1'b0;
      parWriteStrobe_q <= 1'b0;
      parReadActive_q <= 1'b0;
      parAddr_q <= 2'h0;
      parRegSel_q <= 4'h0;
      parWriteData_q <= hpm_pkg::RESET_BYTE;
    end else begin
      writeAct_q <= writeAct;
      parWriteStrobe_q <= writeAct_q && !writeAct;
      parReadActive_q <= readWin;
      // Address tracked only while selected, so it is stable at strobe end
      if (isPar && csLow) begin
        parAddr_q <= syncB_q[hpm_pkg::PIN_ADDR1:hpm_pkg::PIN_ADDR0];
        parRegSel_q <= 4'h1 << syncB_q[hpm_pkg::PIN_ADDR1:hpm_pkg::PIN_ADDR0];
      end
      if (writeAct) begin
        parWriteData_q <= syncB_q[DW-1:0];
      end
    end
  end

  // ==================================================================
  // Serial control port inputs and pin readback
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      serialClk_q <= 1'b0;
      spiDataIn_q <= 1'b0;
      spiCsN_q <= 1'b1;
      i2cDataIn_q <= 1'b1;
      gpioIn_q <= '0;
    end else begin
      serialClk_q <= isSer && syncB_q[hpm_pkg::PIN_ADDR0];
      spiDataIn_q <= isSpi && syncB_q[hpm_pkg::PIN_ADDR1];
      spiCsN_q <= !(isSpi && csLow);
      i2cDataIn_q <= !isI2c || syncB_q[hpm_pkg::PIN_SDIO];
      gpioIn_q <= syncB_q[hpm_pkg::GPIO_COUNT-1:0];
    end
  end

  // ==================================================================
  // Data pin roles, one mux per pin
  for (genvar i = 0; i < DW; i++) begin : g_data
    // Nothing is driven until the mode is known
    assign dataOut_d[i] = !latched_q ? 1'b0 :
                          isPar ? parReadData[i] :
                          extMemEnable ? memAddrData[i] : gpioOut[i];
    assign dataOen_d[i] = !latched_q ? 1'b1 :
                          isPar ? !readWin :
                          extMemEnable ? !memDrive :
                          !gpioDir[i];
  end

  // Control pin roles
  always_comb begin
    rdOut_d = 1'b1;
    rdOen_d = 1'b1;
    wrOut_d = 1'b1;
    wrOen_d = 1'b1;
    sdioOut_d = 1'b1;
    sdioOen_d = 1'b1;
    extOut_d = 1'b1;
    extOen_d = 1'b1;
    if (isSer && extMemEnable) begin
      rdOut_d = memOeN;
      rdOen_d = 1'b0;
      wrOut_d = memWeN;
      wrOen_d = 1'b0;
      extOut_d = romSelN;
      extOen_d = 1'b0;
    end else if (isSer) begin
      rdOut_d = gpioOut[hpm_pkg::PIN_RD];
      rdOen_d = !gpioDir[hpm_pkg::PIN_RD];
      wrOut_d = gpioOut[hpm_pkg::PIN_WR];
      wrOen_d = !gpioDir[hpm_pkg::PIN_WR];
    end
    if (latched_q && !(isSer && extMemEnable)) begin
      extOut_d = gpioOut[hpm_pkg::PIN_EXT_SEL];
      extOen_d = !gpioDir[hpm_pkg::PIN_EXT_SEL];
    end
    if (isPar) begin
      sdioOut_d = gpioOut[hpm_pkg::PIN_SDIO];
      sdioOen_d = !gpioDir[hpm_pkg::PIN_SDIO];
    end else if (isSpi) begin
      sdioOut_d = spiOut;
      sdioOen_d = !csLow;
    end else if (isI2c) begin
      sdioOut_d = 1'b0;
      sdioOen_d = !i2cDriveLow;
    end
  end

  // Pin drive registers, every enable off during reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dataOut_q <= '0;
      dataOen_q <= '1;
      rdOut_q <= 1'b1;
      rdOen_q <= 1'b1;
      wrOut_q <= 1'b1;
      wrOen_q <= 1'b1;
      sdioOut_q <= 1'b1;
      sdioOen_q <= 1'b1;
      extOut_q <= 1'b1;
      extOen_q <= 1'b1;
    end else begin
      dataOut_q <= dataOut_d;
      dataOen_q <= dataOen_d;
      rdOut_q <= rdOut_d;
      rdOen_q <= rdOen_d;
      wrOut_q <= wrOut_d;
      wrOen_q <= wrOen_d;
      sdioOut_q <= sdioOut_d;
      sdioOen_q <= sdioOen_d;
      extOut_q <= extOut_d;
      extOen_q <= extOen_d;
    end
  end

  // ==================================================================
  // Outputs
  assign pins.dataDevOut = dataOut_q;
  assign pins.dataDevOen = dataOen_q;
  assign pins.rdDevOut = rdOut_q;
  assign pins.rdDevOen = rdOen_q;
  assign pins.wrDevOut = wrOut_q;
  assign pins.wrDevOen = wrOen_q;
  assign pins.sdioDevOut = sdioOut_q;
  assign pins.sdioDevOen = sdioOen_q;
  assign pins.extSelDevOut = extOut_q;
  assign pins.extSelDevOen = extOen_q;
  assign modeValid = latched_q;
  assign hostMode = mode_q;
  assign dirStyle = dirStyle_q;
  assign autoBootStart = autoBoot_q;
  assign usePll = usePll_q;
  assign parAddr = parAddr_q;
  assign parRegSel = parRegSel_q;
  assign parWriteData = parWriteData_q;
  assign parWriteStrobe = parWriteStrobe_q;
  assign parReadActive = parReadActive_q;
  assign serialClk = serialClk_q;
  assign spiDataIn = spiDataIn_q;
  assign spiCsN = spiCsN_q;
  assign i2cDataIn = i2cDataIn_q;
  assign gpioIn = gpioIn_q;

endmodule

/* hw/hpm_host_end.sv */
// Host end: strap driver and parallel bus master behind APB registers
`timescale 1ns/1ns
module hpm_host_end #(
  parameter logic STRAP_RD = 1'b1,
  parameter logic STRAP_WR = 1'b1,
  parameter logic STRAP_PSEL = 1'b1,
  parameter logic STRAP_AUTO_BOOT_REQUEST_N = 1'b1,
  parameter logic STRAP_CORE_CLOCK_SOURCE_SELECT = 1'b0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  hpm_pins_if.host pins
);

  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} hpm_hstate_t;

  hpm_hstate_t state_q;
  logic [3:0] cnt_q;
  logic strapDrive_q, parEn_q, dirMode_q, core_clock_source_select_q;
  logic cmdWrite_q;
  logic [1:0] cmdAddr_q;
  logic [7:0] cmdData_q, rdata_q;
  logic [7:0] syncA_q, syncB_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, apbWr, busy, strobing;
  logic rdOut_q, wrOut_q, ctlOen_q, csN_q;
  logic [7:0] dataOen_q;

  // ==================================================================
  // APB slave, one wait-free access cycle, answer registered at setup
  assign apbWr = psel && penable && pready_q && pwrite;
  assign busy = (state_q != H_IDLE);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && (paddr != hpm_pkg::REG_CTRL)
                   && (paddr != hpm_pkg::REG_CMD) && (paddr != hpm_pkg::REG_STATUS);
      if (paddr == hpm_pkg::REG_CTRL) begin
        prdata_q <= {28'h0, core_clock_source_select_q, dirMode_q, parEn_q, !strapDrive_q};
      end else if (paddr == hpm_pkg::REG_STATUS) begin
        prdata_q <= {16'h0, rdata_q, 6'h0, strapDrive_q, busy};
      end else begin
        prdata_q <= 32'h0;
      end
    end
  end

  // Control register; straps held until software releases them
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strapDrive_q <= 1'b1;
      parEn_q <= 1'b0;
      dirMode_q <= 1'b0;
      core_clock_source_select_q <= STRAP_CORE_CLOCK_SOURCE_SELECT;
    end else if (apbWr && paddr == hpm_pkg::REG_CTRL) begin
      strapDrive_q <= strapDrive_q && !pwdata[hpm_pkg::CTRL_RELEASE_BIT];
      parEn_q <= pwdata[hpm_pkg::CTRL_PAR_BIT];
      dirMode_q <= pwdata[hpm_pkg::CTRL_DIR_BIT];
      core_clock_source_select_q <= pwdata[hpm_pkg::CTRL_CORE_CLOCK_SOURCE_SELECT_BIT];
    end
  end

  // ==================================================================
  // Parallel transfer sequencer; commands while busy are dropped
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= H_IDLE;
      cnt_q <= 4'h0;
      cmdWrite_q <= 1'b0;
      cmdAddr_q <= 2'h0;
      cmdData_q <= hpm_pkg::RESET_BYTE;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      case (state_q)
        H_IDLE: begin
          cnt_q <= 4'h1;
          if (apbWr && paddr == hpm_pkg::REG_CMD && parEn_q && !strapDrive_q) begin
            state_q <= H_SETUP;
            cmdWrite_q <= pwdata[hpm_pkg::CMD_WRITE_BIT];
            cmdAddr_q <= pwdata[hpm_pkg::CMD_ADDR_LSB +: 2];
            cmdData_q <= pwdata[7:0];
          end
        end
        H_SETUP: begin
          if (cnt_q == hpm_pkg::SETUP_CYCLES) begin
            state_q <= H_STROBE;
            cnt_q <= 4'h1;
          end
        end
        H_STROBE: begin
          if (cnt_q == hpm_pkg::STROBE_CYCLES) begin
            state_q <= H_HOLD;
            cnt_q <= 4'h1;
          end
        end
        default: begin
          if (cnt_q == hpm_pkg::HOLD_CYCLES) begin
            state_q <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Read data taken at the end of the strobe, after the device turned on
  always_ff @(posedge core_clk) begin
    syncA_q <= pins.dataLine;
    syncB_q <= syncA_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_q <= hpm_pkg::RESET_BYTE;
    end else if (state_q == H_STROBE && cnt_q == hpm_pkg::STROBE_CYCLES && !cmdWrite_q) begin
      rdata_q <= syncB_q;
    end
  end

  // ==================================================================
  // Pin drive
  assign strobing = (state_q == H_STROBE);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdOut_q <= STRAP_RD;
      wrOut_q <= STRAP_WR;
      ctlOen_q <= 1'b0;
      csN_q <= 1'b1;
      dataOen_q <= 8'hFF;
    end else if (strapDrive_q) begin
      rdOut_q <= STRAP_RD;
      wrOut_q <= STRAP_WR;
      ctlOen_q <= 1'b0;
      csN_q <= 1'b1;
      dataOen_q <= 8'hFF;
    end else begin
      // Direction style: read pin carries R/W, write pin the data strobe
      rdOut_q <= dirMode_q ? (!busy || !cmdWrite_q) : !(strobing && !cmdWrite_q);
      wrOut_q <= !(strobing && (dirMode_q || cmdWrite_q));
      ctlOen_q <= !parEn_q;
      csN_q <= !busy;
      dataOen_q <= (busy && cmdWrite_q) ? 8'h00 : 8'hFF;
    end
  end

  assign pins.rdHostOut = rdOut_q;
  assign pins.wrHostOut = wrOut_q;
  assign pins.rdHostOen = ctlOen_q;
  assign pins.wrHostOen = ctlOen_q;
  assign pins.sdioHostOut = STRAP_PSEL;
  assign pins.sdioHostOen = !strapDrive_q;
  assign pins.abootHostOut = STRAP_AUTO_BOOT_REQUEST_N;
  assign pins.abootHostOen = !strapDrive_q;
  assign pins.dataHostOut = cmdData_q;
  assign pins.dataHostOen = dataOen_q;
  assign pins.addr0 = cmdAddr_q[0];
  assign pins.addr1 = cmdAddr_q[1];
  assign pins.csN = csN_q;
  assign pins.core_clock_source_select = core_clock_source_select_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule

/* test/hpm_pins_sva.sv */
// Checker for the shared host pins between the two ends
`timescale 1ns/1ns
module hpm_pins_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic rdLine,
  input wire logic wrLine,
  input wire logic sdioLine,
  input wire logic abootLine,
  input wire logic [7:0] dataDevOen,
  input wire logic rdDevOen,
  input wire logic wrDevOen,
  input wire logic sdioDevOen,
  input wire logic extSelDevOen
);
  // ==================================================================
  // Frame phases of one parallel transfer
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  sequence setupPhase;
    wrLine [*4] ##1 !wrLine;
  endsequence
  sequence strobePhase;
    !wrLine [*8] ##1 wrLine;
  endsequence
  sequence csLow16;
    !csN [*8] ##1 !csN [*8];
  endsequence

  // ==================================================================
  // Pin roles
  a_release_inputs: assert property ($rose(rstn) |-> &{dataDevOen, rdDevOen, wrDevOen, sdioDevOen, extSelDevOen})
    else $error("device drives a pin out of reset");
  a_straps_held: assert property ($rose(rstn) |-> rdLine && wrLine && sdioLine && abootLine && csN)
    else $error("strap levels lost at reset release");
  a_frame_length: assert property ($fell(csN) |-> csLow16 ##1 csN)
    else $error("chip select frame length wrong");
  a_setup_phase: assert property ($fell(csN) |-> setupPhase)
    else $error("strobe setup length wrong");
  a_strobe_width: assert property ($fell(wrLine) && !csN |-> strobePhase)
    else $error("strobe width wrong");
  a_read_drive: assert property ($fell(wrLine) && rdLine && !csN |-> ##[1:4] (dataDevOen == 8'h00))
    else $error("device silent on a read");
  a_write_quiet: assert property ((!csN && !rdLine) [*4] |-> &dataDevOen)
    else $error("device drives data on a write");
  a_idle_quiet: assert property (csN [*4] |-> &dataDevOen)
    else $error("device drives data while deselected");
endmodule

/* test/host_port_pin_mode_select_tb.sv */
// Testbench joining the device end and the host end across the pins
`timescale 1ns/1ns
module host_port_pin_mode_select_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [11:0] gpioOut = 12'h000, gpioDir = 12'h000;
  logic [7:0] memAddrData = 8'h00, parReadData = 8'h00, parWriteData;
  logic [6:0] misc = 7'h00;
  logic modeValid, dirStyle, autoBootStart, usePll, parWriteStrobe, parReadActive;
  logic serialClk, spiDataIn, spiCsN, i2cDataIn;
  logic [11:0] gpioIn;
  int rdCnt = 0;
  hpm_pkg::hpm_mode_t hostMode;
  logic [1:0] parAddr;
  logic [3:0] parRegSel;
  logic [31:0] seed = 32'h417D;
  logic [33:0] apbQ[$];
  logic [33:0] note;
  logic [9:0] parQ[$];
  logic [9:0] pn;
  logic bootSeen = 1'b0;
  int n_fail = 0;
  int comparisons = 0;

  // ==================================================================
  // Clock, wiring and checker
  always #10 core_clk = ~core_clk;
  hpm_pins_if pins ();
  hpm_device_end u_hpm_device_end (.core_clk(core_clk), .rstn(rstn), .pins(pins),
    .extMemEnable(misc[0]), .gpioOut(gpioOut), .gpioDir(gpioDir), .memAddrData(memAddrData),
    .memDrive(misc[1]), .memOeN(misc[2]), .memWeN(misc[3]), .romSelN(misc[4]),
    .parReadData(parReadData), .spiOut(misc[5]), .i2cDriveLow(misc[6]), .modeValid(modeValid),
    .hostMode(hostMode), .dirStyle(dirStyle), .autoBootStart(autoBootStart), .usePll(usePll),
    .parAddr(parAddr), .parRegSel(parRegSel), .parWriteData(parWriteData),
    .parWriteStrobe(parWriteStrobe), .parReadActive(parReadActive), .serialClk(serialClk),
    .spiDataIn(spiDataIn), .spiCsN(spiCsN), .i2cDataIn(i2cDataIn), .gpioIn(gpioIn));
  hpm_host_end u_hpm_host_end (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins));
  hpm_pins_sva u_sva (.core_clk(core_clk), .rstn(rstn), .csN(pins.csN), .rdLine(pins.rdLine),
    .wrLine(pins.wrLine), .sdioLine(pins.sdioLine), .abootLine(pins.abootLine),
    .dataDevOen(pins.dataDevOen), .rdDevOen(pins.rdDevOen), .wrDevOen(pins.wrDevOen),
    .sdioDevOen(pins.sdioDevOen), .extSelDevOen(pins.extSelDevOen));

  // ==================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", what, e, s);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One APB transfer; the expected answer is noted before it starts
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] e);
    int i;
    apbQ.push_back({~wr, err, e});
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait for one whole chip select frame
  task automatic waitFrame();
    int i, j;
    for (i = 0; i < 60 && pins.csN !== 1'b0; i++) @(posedge core_clk);
    for (j = 0; j < 60 && pins.csN !== 1'b1; j++) @(posedge core_clk);
    // A frame that never starts is a hang as well, not a pass
    if (i == 60 || pins.csN !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask

  // ==================================================================
  // Random processor controls; in parallel mode only the SDIO and ext select GPIO bits reach the pins
  always @(posedge core_clk) begin
    {gpioOut, gpioDir, memAddrData} <= rnd();
    misc <= 7'(rnd());
  end
  // Oldest note is compared whenever an access or a device write completes
  always @(posedge core_clk) begin
    if (autoBootStart === 1'b1) bootSeen <= 1'b1;
    if (parReadActive === 1'b1) rdCnt++;
    if (rstn && psel && penable && pready === 1'b1) begin
      note = apbQ.size() ? apbQ.pop_front() : 34'h0;
      chk("pslverr", pslverr, note[32]);
      if (note[33]) chk("prdata", prdata, note[31:0]);
    end
    if (parWriteStrobe === 1'b1) begin
      pn = parQ.size() ? parQ.pop_front() : 10'h3FF;
      chk("par write", {parAddr, parWriteData}, pn);
      chk("reg select", parRegSel, 4'h1 << pn[9:8]);
    end
  end

  // ==================================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [1:0] a;
    int k;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    apb(1'b0, hpm_pkg::REG_STATUS, 32'h0, 1'b0, 32'h2);
    chk("valid", modeValid, 1'b1);
    chk("mode", hostMode, hpm_pkg::HPM_PAR);
    chk("style", dirStyle, 1'b1);
    chk("pll", usePll, 1'b1);
    apb(1'b0, 8'h0C, 32'h0, 1'b1, 32'h0);
    apb(1'b1, 8'h10, 32'hFFFFFFFF, 1'b1, 32'h0);
    apb(1'b1, hpm_pkg::REG_CTRL, 32'h7, 1'b0, 32'h0);
    apb(1'b0, hpm_pkg::REG_CTRL, 32'h0, 1'b0, 32'h7);
    for (k = 0; k < 4; k++) begin
      d = 8'(rnd());
      a = 2'(k);
      parQ.push_back({a, d});
      apb(1'b1, hpm_pkg::REG_CMD, {21'h0, 1'b1, a, d}, 1'b0, 32'h0);
      waitFrame();
      d = 8'(rnd());
      parReadData <= d;
      apb(1'b1, hpm_pkg::REG_CMD, {22'h0, a, 8'h00}, 1'b0, 32'h0);
      waitFrame();
      apb(1'b0, hpm_pkg::REG_STATUS, 32'h0, 1'b0, {16'h0, d, 8'h00});
    end
    apb(1'b1, hpm_pkg::REG_CTRL, 32'hF, 1'b0, 32'h0);
    for (k = 0; k < 10 && usePll !== 1'b0; k++) @(posedge core_clk);
    chk("pll bypass", usePll, 1'b0);
    chk("autoboot", bootSeen, 1'b0);
    chk("par notes", parQ.size(), 32'h0);
    // One read window per strobe cycle of each of the four reads
    chk("read cycles", rdCnt, 32'h4 * hpm_pkg::STROBE_CYCLES);
    // Serial roles stay gated off while the parallel mode is latched
    chk("serial idle", {serialClk, spiDataIn, spiCsN, i2cDataIn}, 4'h3);
    // Idle bus: host holds rd and wr high, data floats on its pull-ups
    chk("pin readback", {gpioIn[11:10], gpioIn[7:0]}, 10'h3FF);
    stop_test();
  end
endmodule
